// ==== design/ppu_rd_pkg.sv ====
// shared constants and carriers for the poll-unconfigure and read block
package ppu_rd_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STAT_OFS   = 8'h04;
	localparam logic [7:0] EOS_OFS    = 8'h08;
	localparam logic [7:0] TMO_OFS    = 8'h0C;
	localparam logic [7:0] PPMASK_OFS = 8'h10;
	localparam logic [7:0] MYADDR_OFS = 8'h14;
	// ctrl bit positions
	localparam int CTRL_SC_BIT   = 0;
	localparam int CTRL_EOS_BIT  = 1;
	localparam int CTRL_CLR_BIT  = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	// ------------------------------------------------------------
	// text and bus constants
	// ------------------------------------------------------------
	localparam logic [7:0] CH_CR    = 8'h0D;
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_SP    = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_HASH  = 8'h23;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NUL   = 8'h00;
	localparam logic [4:0] ADDR_MAX = 5'h1E;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE   = 8'h40;
	localparam logic [7:0] UNL_CMD     = 8'h3F;
	localparam logic [7:0] PPU_CMD     = 8'h15;
	localparam logic [7:0] PPD_CMD     = 8'h70;
	localparam logic [16:0] CNT_MAX    = 17'h0FFFF;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ     = 10_000_000;
	localparam int TMO_SEC    = 10;
	localparam int TMO_CYC    = CLK_HZ * TMO_SEC;
	localparam int IFC_US     = 100;
	localparam int IFC_CYC    = (IFC_US * (CLK_HZ / 1_000_000));
	// error codes
	typedef enum logic [1:0] {
		ERR_NONE = 2'h0,
		ERR_CIC  = 2'h1,
		ERR_ABO  = 2'h2,
		ERR_ARG  = 2'h3
	} err_t;
	// one byte heading out on a stream
	typedef struct packed {
		logic       valid;
		logic       atn;
		logic [7:0] data;
	} bus_out_t;
	// one byte arriving from the bus
	typedef struct packed {
		logic       valid;
		logic       eoi;
		logic [7:0] data;
	} bus_in_t;
endpackage : ppu_rd_pkg

// ==== design/ppu_rd_core.sv ====
// command interpreter for poll-unconfigure and counted bus read
// Functional notes
// - address values keep only low five bits; valid range 0 to 30, 31 not rejected
// - address is primary, optional plus and secondary, decimal text
// - listen base 32 and talk base 64 decode as bare primary
// - list separators are comma or space; lines end in CR
// - poll-unconfigure with list disables only listed devices
// - poll-unconfigure without list unconfigures every device
// - own address listed stops own parallel-poll response
// - first controller command pulses IFC if system controller, then REN
// - control passed away blocks ppu and addressed read, records not-controller error
// - read count is hash-prefixed decimal from 1 to 65535
// - read stops on count, END, end-of-string byte or timeout
// - reply data, nulls to count, decimal count, CR LF
// - read timeout aborts read, records timeout error; default 10 s
// - as controller, address self listener and talker if given
// - after addressing enter standby with ATN released, stay there
// - read with talker address needs controller in charge
// - not controller, no address: read proceeds, waits to be addressed
// - read without argument records missing-argument error
// - power-on enables system-controller capability
`timescale 1ns/1ps
module ppu_rd_core
	import ppu_rd_pkg::*;
#(
	parameter int TMO_DEF = TMO_CYC
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [7:0]         cmd_char,
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	output logic [7:0]              rsp_char,
	output logic                    rsp_valid,
	input  wire logic               rsp_ready,
	output ppu_rd_pkg::bus_out_t    gp_tx,
	input  wire logic               gp_tx_ack,
	input  wire ppu_rd_pkg::bus_in_t gp_rx,
	input  wire logic               cic_lost,
	output logic                    ifc_out,
	output logic                    ren_out,
	output logic                    atn_out,
	output logic                    own_pp_en
);
	import ppu_rd_pkg::*;
	initial begin
		if (TMO_DEF < 1) $error("timeout must be positive");
	end
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [11:0] {
		S_IDLE = 12'h001, S_CMD  = 12'h002, S_ARG  = 12'h004,
		S_IFC  = 12'h008, S_PPU  = 12'h010, S_ADR  = 12'h020,
		S_READ = 12'h040, S_PAD  = 12'h080, S_NUM  = 12'h100,
		S_CRLF = 12'h200, S_SKIP = 12'h400, S_DONE = 12'h800
	} st_t;
	st_t st_q, st_d;
	// command kind: 0 ppu, 1 rd
	logic        isrd_q, isrd_d;
	logic [7:0]  c0_q, c0_d;
	logic [16:0] num_q, num_d;
	logic [16:0] cnt_q, cnt_d, got_q, got_d;
	logic        hash_q, hash_d, plus_q, plus_d, dig_q, dig_d;
	logic        argany_q, argany_d, tad_q, tad_d, eol_q, eol_d;
	logic [4:0]  pri_q, pri_d, sec_q, sec_d;
	logic        sec_v_q, sec_v_d;
	logic [2:0]  seq_q, seq_d;
	logic [31:0] tmr_q, tmr_d;
	logic        cic_q, cic_d, ifc_q, ifc_d, ren_q, ren_d, atn_q, atn_d;
	logic        own_q, own_d, pend_q, pend_d;
	logic [31:0] ppm_q, ppm_d;
	err_t        err_q, err_d;
	logic [7:0]  rc_q, rc_d;
	logic        rv_q, rv_d;
	bus_out_t    tx_q, tx_d;
	logic [19:0] dec_q, dec_d;
	logic [2:0]  nd_q, nd_d;
	logic        cr_q, cr_d;
	// register file
	logic [31:0] ctrl_q, eos_q, tmo_q, my_q;
	logic        wr_q;
	logic [7:0]  wa_q;
	logic        clr_req;
	// ------------------------------------------------------------
	// ahb slave: zero wait, always okay
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		unique case (haddr[7:0])
			CTRL_OFS:   rd_mux = ctrl_q;
			// byte count sits above the flags so the two never overlap
			STAT_OFS:   rd_mux = {got_q[15:0], 10'h0, err_q,
			            cic_q, ren_q, st_q == S_IDLE, 1'b0};
			EOS_OFS:    rd_mux = eos_q;
			TMO_OFS:    rd_mux = tmo_q;
			PPMASK_OFS: rd_mux = ppm_q;
			MYADDR_OFS: rd_mux = my_q;
			default:    rd_mux = 32'h0000_0000;
		endcase
	end
	assign clr_req = wr_q && wa_q == CTRL_OFS && hwdata[CTRL_CLR_BIT];
	// register writes land in data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0; wa_q <= 8'h00; hrdata <= 32'h0000_0000;
			ctrl_q <= CTRL_RST; eos_q <= 32'h0000_000A;
			tmo_q <= 32'(TMO_DEF); my_q <= 32'h0000_0000;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			wa_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) hrdata <= rd_mux;
			if (wr_q) begin
				unique case (wa_q)
					CTRL_OFS: ctrl_q <= {29'h0, 1'b0, hwdata[1:0]};
					EOS_OFS:  eos_q  <= {24'h0, hwdata[7:0]};
					TMO_OFS:  tmo_q  <= (hwdata == 32'h0) ? 32'h1 : hwdata;
					MYADDR_OFS: my_q <= {27'h0, hwdata[4:0]};
					default: ;
				endcase
			end
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// ------------------------------------------------------------
	// interpreter next state
	// ------------------------------------------------------------
	logic [7:0] ch;
	logic       take, sep, digit;
	assign ch = cmd_char;
	assign digit = ch >= CH_ZERO && ch <= 8'h39;
	assign sep = ch == CH_SP || ch == CH_COMMA;
	assign cmd_ready = (st_q == S_IDLE || st_q == S_CMD || st_q == S_ARG
	                   || st_q == S_SKIP);
	assign take = cmd_valid && cmd_ready;
	always_comb begin
		st_d = st_q; isrd_d = isrd_q; c0_d = c0_q; num_d = num_q;
		cnt_d = cnt_q; got_d = got_q; hash_d = hash_q; plus_d = plus_q;
		dig_d = dig_q; argany_d = argany_q; tad_d = tad_q; eol_d = eol_q;
		pri_d = pri_q; sec_d = sec_q; sec_v_d = sec_v_q; seq_d = seq_q;
		tmr_d = tmr_q; cic_d = cic_q; ifc_d = ifc_q; ren_d = ren_q;
		atn_d = atn_q; own_d = own_q; pend_d = pend_q; ppm_d = ppm_q;
		err_d = err_q; rc_d = rc_q; rv_d = rv_q; tx_d = tx_q;
		dec_d = dec_q; nd_d = nd_q; cr_d = cr_q;
		if (clr_req) err_d = ERR_NONE;
		if (rv_q && rsp_ready) rv_d = 1'b0;
		if (tx_q.valid && gp_tx_ack) tx_d.valid = 1'b0;
		if (cic_lost) begin
			cic_d = 1'b0;
		end
		unique case (st_q)
			S_IDLE: if (take) begin
				c0_d = ch; st_d = S_CMD; num_d = '0; hash_d = 1'b0;
				plus_d = 1'b0; dig_d = 1'b0; argany_d = 1'b0;
				tad_d = 1'b0; sec_v_d = 1'b0; cnt_d = '0; pend_d = 1'b0;
			end
			S_CMD: if (take) begin
				// first letter picks the command
				isrd_d = (c0_q | 8'h20) == 8'h72;
				st_d = S_SKIP;
			end
			S_SKIP: if (take) begin
				if (ch == CH_CR) begin
					eol_d = 1'b1; st_d = S_ARG;
				end else if (sep) st_d = S_ARG;
			end
			S_ARG: if (take || eol_q) begin
				if (!eol_q && digit) begin
					num_d = 17'(num_q * 17'd10 + 17'(ch - CH_ZERO));
					dig_d = 1'b1;
				end else if (!eol_q && ch == CH_HASH) begin
					hash_d = 1'b1;
				end else if (!eol_q && ch == CH_PLUS) begin
					// keep low five bits; bases fold away
					pri_d = num_q[4:0]; plus_d = 1'b1;
					num_d = '0; dig_d = 1'b0;
				end else begin
					// comma, space or CR end an item
					if (dig_q && hash_q) begin
						cnt_d = (num_q > CNT_MAX) ? CNT_MAX : num_q;
						argany_d = 1'b1; hash_d = 1'b0;
					end else if (dig_q) begin
						argany_d = 1'b1; tad_d = 1'b1;
						if (plus_q) begin
							sec_d = num_q[4:0]; sec_v_d = 1'b1;
						end else pri_d = num_q[4:0];
						if (!isrd_q) pend_d = 1'b1;
					end
					num_d = '0; dig_d = 1'b0; plus_d = 1'b0;
					if (ch == CH_CR || eol_q) eol_d = 1'b1;
					if (dig_q && !isrd_q) st_d = S_IFC;
					else if (ch == CH_CR || eol_q) st_d = S_IFC;
				end
			end
			S_IFC: begin
				if (isrd_q && cnt_q == 17'h0) begin
					err_d = ERR_ARG; st_d = S_DONE;
				end else if (isrd_q && !tad_q && !cic_q) begin
					st_d = S_READ; tmr_d = tmo_q; got_d = '0;
				end else if (!cic_q && (!ctrl_q[CTRL_SC_BIT] || ren_q)) begin
					// no control, refuse; ren marks not first
					err_d = ERR_CIC; st_d = S_DONE;
				end else if (!cic_q) begin
					// pulse interface clear then remote enable
					ifc_d = 1'b1;
					if (tmr_q == 32'(IFC_CYC)) begin
						ifc_d = 1'b0; ren_d = 1'b1; cic_d = 1'b1;
						tmr_d = '0;
					end else tmr_d = tmr_q + 32'h1;
				end else begin
					st_d = isrd_q ? S_ADR : S_PPU; seq_d = '0;
					atn_d = 1'b1; tmr_d = '0;
				end
			end
			S_PPU: if (!tx_q.valid) begin
				if (!argany_q && !pend_q) begin
					tx_d = '{1'b1, 1'b1, PPU_CMD}; ppm_d = '0;
					own_d = 1'b0; st_d = S_DONE;
				end else if (seq_q == 3'h0) begin
					tx_d = '{1'b1, 1'b1, UNL_CMD}; seq_d = 3'h1;
				end else if (seq_q == 3'h1) begin
					tx_d = '{1'b1, 1'b1, LISTEN_BASE | {3'h0, pri_q}};
					seq_d = 3'h2;
				end else if (seq_q == 3'h2) begin
					tx_d = '{1'b1, 1'b1, PPD_CMD}; seq_d = 3'h3;
					ppm_d[pri_q] = 1'b0;
					if (pri_q == my_q[4:0]) own_d = 1'b0;
				end else begin
					tx_d = '{1'b1, 1'b1, UNL_CMD}; seq_d = 3'h0;
					pend_d = 1'b0;
					st_d = eol_q ? S_DONE : S_ARG;
				end
			end
			S_ADR: if (!tx_q.valid) begin
				if (seq_q == 3'h0) begin
					tx_d = '{1'b1, 1'b1, UNL_CMD}; seq_d = 3'h1;
				end else if (seq_q == 3'h1) begin
					tx_d = '{1'b1, 1'b1, LISTEN_BASE | {3'h0, my_q[4:0]}};
					seq_d = tad_q ? 3'h2 : 3'h4;
				end else if (seq_q == 3'h2) begin
					tx_d = '{1'b1, 1'b1, TALK_BASE | {3'h0, pri_q}};
					seq_d = sec_v_q ? 3'h3 : 3'h4;
				end else if (seq_q == 3'h3) begin
					tx_d = '{1'b1, 1'b1, 8'h60 | {3'h0, sec_q}};
					seq_d = 3'h4;
				end else begin
					atn_d = 1'b0; st_d = S_READ;
					tmr_d = tmo_q; got_d = '0;
				end
			end
			S_READ: begin
				tmr_d = tmr_q - 32'h1;
				if (gp_rx.valid) begin
					got_d = got_q + 17'h1; rc_d = gp_rx.data; rv_d = 1'b1;
				end
				if (gp_rx.valid && (got_q + 17'h1 == cnt_q || gp_rx.eoi
				    || (ctrl_q[CTRL_EOS_BIT] && gp_rx.data == eos_q[7:0])))
					st_d = S_PAD;
				else if (tmr_q <= 32'h1) begin
					err_d = ERR_ABO; st_d = S_PAD;
				end
				if (gp_rx.valid) nd_d = 3'h0;
				num_d = got_d;
			end
			S_PAD: if (!rv_q || rsp_ready) begin
				// nulls up to the requested count
				if (num_q < cnt_q) begin
					rc_d = CH_NUL; rv_d = 1'b1; num_d = num_q + 17'h1;
				end else begin
					st_d = S_NUM; dec_d = {3'h0, got_q}; nd_d = 3'h0;
				end
			end
			S_NUM: begin
				// build decimal digits into a small stack
				if (dec_q >= 20'd10000 && nd_q == 3'h0) nd_d = 3'h5;
				else if (dec_q >= 20'd1000 && nd_q == 3'h0) nd_d = 3'h4;
				else if (dec_q >= 20'd100 && nd_q == 3'h0) nd_d = 3'h3;
				else if (dec_q >= 20'd10 && nd_q == 3'h0) nd_d = 3'h2;
				else if (nd_q == 3'h0) nd_d = 3'h1;
				else if (!rv_q || rsp_ready) begin
					unique case (nd_q)
						3'h5: rc_d = CH_ZERO + 8'(dec_q / 20'd10000);
						3'h4: rc_d = CH_ZERO + 8'((dec_q / 20'd1000) % 10);
						3'h3: rc_d = CH_ZERO + 8'((dec_q / 20'd100) % 10);
						3'h2: rc_d = CH_ZERO + 8'((dec_q / 20'd10) % 10);
						default: rc_d = CH_ZERO + 8'(dec_q % 20'd10);
					endcase
					rv_d = 1'b1; nd_d = nd_q - 3'h1;
					if (nd_q == 3'h1) begin
						st_d = S_CRLF; cr_d = 1'b0;
					end
				end
			end
			S_CRLF: if (!rv_q || rsp_ready) begin
				rc_d = cr_q ? CH_LF : CH_CR; rv_d = 1'b1; cr_d = 1'b1;
				if (cr_q) st_d = S_DONE;
			end
			S_DONE: if (!tx_q.valid) begin
				st_d = S_IDLE; eol_d = 1'b0; tmr_d = '0;
			end
			default: st_d = S_IDLE;
		endcase
	end
	// state registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= S_IDLE; isrd_q <= 1'b0; c0_q <= 8'h00; num_q <= '0;
			cnt_q <= '0; got_q <= '0; hash_q <= 1'b0; plus_q <= 1'b0;
			dig_q <= 1'b0; argany_q <= 1'b0; tad_q <= 1'b0; eol_q <= 1'b0;
			pri_q <= '0; sec_q <= '0; sec_v_q <= 1'b0; seq_q <= '0;
			tmr_q <= '0; cic_q <= 1'b0; ifc_q <= 1'b0; ren_q <= 1'b0;
			atn_q <= 1'b0; own_q <= 1'b1; pend_q <= 1'b0;
			ppm_q <= 32'h7FFF_FFFF; err_q <= ERR_NONE; rc_q <= 8'h00;
			rv_q <= 1'b0; tx_q <= '0; dec_q <= '0; nd_q <= '0; cr_q <= 1'b0;
		end else begin
			st_q <= st_d; isrd_q <= isrd_d; c0_q <= c0_d; num_q <= num_d;
			cnt_q <= cnt_d; got_q <= got_d; hash_q <= hash_d;
			plus_q <= plus_d; dig_q <= dig_d; argany_q <= argany_d;
			tad_q <= tad_d; eol_q <= eol_d; pri_q <= pri_d; sec_q <= sec_d;
			sec_v_q <= sec_v_d; seq_q <= seq_d; tmr_q <= tmr_d;
			cic_q <= cic_d; ifc_q <= ifc_d; ren_q <= ren_d; atn_q <= atn_d;
			own_q <= own_d; pend_q <= pend_d; ppm_q <= ppm_d;
			err_q <= err_d; rc_q <= rc_d; rv_q <= rv_d; tx_q <= tx_d;
			dec_q <= dec_d; nd_q <= nd_d; cr_q <= cr_d;
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rsp_char = rc_q;
	assign rsp_valid = rv_q;
	assign gp_tx = tx_q;
	assign ifc_out = ifc_q;
	assign ren_out = ren_q;
	assign atn_out = atn_q;
	assign own_pp_en = own_q;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_err_arg;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_IFC && isrd_q && cnt_q == 17'h0) |=> err_q == ERR_ARG;
	endproperty
	a_err_arg: assert property (p_err_arg) else $error("no arg error");
	property p_cic;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_IFC && !cic_q && (!ctrl_q[0] || ren_q)
		 && !(isrd_q && !tad_q)
		 && !(isrd_q && cnt_q == 17'h0)) |=> err_q == ERR_CIC;
	endproperty
	a_cic: assert property (p_cic) else $error("no cic error");
	property p_ren;
		@(posedge hclk) disable iff (!hresetn)
		$fell(ifc_q) |-> ren_q && cic_q;
	endproperty
	a_ren: assert property (p_ren) else $error("ren missing");
	property p_atn;
		@(posedge hclk) disable iff (!hresetn)
		st_q == S_READ |-> !atn_q;
	endproperty
	a_atn: assert property (p_atn) else $error("atn in read");
	property p_univ;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_PPU && !argany_q && !pend_q && !tx_q.valid)
		|=> ppm_q == 32'h0 && !own_q;
	endproperty
	a_univ: assert property (p_univ) else $error("ppu all");
	property p_eoi;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_READ && gp_rx.valid && gp_rx.eoi) |=> st_q == S_PAD;
	endproperty
	a_eoi: assert property (p_eoi) else $error("end ignored");
	property p_tmo;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_READ && !gp_rx.valid && tmr_q == 32'h1)
		|=> err_q == ERR_ABO;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout lost");
	property p_pad;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == S_PAD && num_q < cnt_q && (!rv_q || rsp_ready))
		|=> rv_q && rc_q == CH_NUL;
	endproperty
	a_pad: assert property (p_pad) else $error("pad not null");
	c_read: cover property (@(posedge hclk) st_q == S_READ ##1 st_q == S_PAD);
	c_ppu:  cover property (@(posedge hclk) st_q == S_PPU && seq_q == 3'h3);
	c_ifc:  cover property (@(posedge hclk) $fell(ifc_q));
endmodule : ppu_rd_core

// ==== tb/gpib_partner.sv ====
// behavioural bus instruments: acknowledge command bytes, talk on demand
`timescale 1ns/1ps
module gpib_partner
	import ppu_rd_pkg::*;
(
	input  wire logic                hclk,
	input  wire ppu_rd_pkg::bus_out_t gp_tx,
	input  wire logic                atn_out,
	input  wire logic [3:0]          ack_dly,
	input  wire logic [7:0]          talk_len,
	input  wire logic                eoi_last,
	input  wire logic                talk_now,
	output logic                     gp_tx_ack,
	output ppu_rd_pkg::bus_in_t      gp_rx
);
	logic [7:0] log_q [$];
	logic [3:0] wait_q  = 4'h0;
	logic [7:0] sent_q  = 8'h00;
	logic [1:0] gap_q   = 2'h0;
	logic       talk_q  = 1'h0;
	logic       armed_q = 1'h0;
	initial begin
		gp_tx_ack = 1'h0;
		gp_rx     = '0;
	end
	// one ack per byte; idle data lines toggle so stale values never match
	always @(posedge hclk) begin
		gp_tx_ack   <= 1'h0;
		gp_rx.valid <= 1'h0;
		gp_rx.eoi   <= 1'h0;
		gp_rx.data  <= ~gp_rx.data;
		gap_q       <= gap_q + 2'h1;
		if (gp_tx.valid === 1'h1 && !gp_tx_ack) begin
			wait_q <= wait_q + 4'h1;
			if (wait_q >= ack_dly) begin
				gp_tx_ack <= 1'h1;
				wait_q    <= 4'h0;
				log_q.push_back(gp_tx.data);
				if (gp_tx.data[7:5] == 3'h2)
					armed_q <= 1'h1;
			end
		end
		// talker, END on last byte when asked
		if ((armed_q && atn_out === 1'h0) || talk_now) begin
			talk_q  <= 1'h1;
			armed_q <= 1'h0;
			sent_q  <= 8'h00;
		end else if (talk_q && gap_q == 2'h3) begin
			gp_rx.valid <= 1'h1;
			gp_rx.eoi   <= eoi_last && (sent_q == talk_len - 8'h01);
			gp_rx.data  <= 8'h41 + sent_q;
			sent_q      <= sent_q + 8'h01;
			talk_q      <= (sent_q + 8'h01) < talk_len;
		end
	end
endmodule : gpib_partner

// ==== tb/test_gpib_poll_unconfig_and_read.sv ====
// self-checking bench for the poll-unconfigure and counted read block
`timescale 1ns/1ps
module test_gpib_poll_unconfig_and_read;
	import ppu_rd_pkg::*;
	typedef struct {
		string      c;
		logic [3:0] d;
		logic [7:0] len;
		logic       eoi;
		logic       eos;
		int         req;
		int         n;
	} row_t;
	logic        hclk      = 1'h0;
	logic        hresetn   = 1'h0;
	logic [31:0] haddr     = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'h0;
	logic [31:0] hwdata    = 32'h0;
	logic [7:0]  cmd_char  = 8'h00;
	logic        cmd_valid = 1'h0;
	logic        rsp_ready = 1'h0;
	logic        cic_lost  = 1'h0;
	logic [3:0]  ack_dly   = 4'h0;
	logic [7:0]  talk_len  = 8'h00;
	logic        eoi_last  = 1'h0;
	logic        talk_now  = 1'h0;
	logic        ifc_prev  = 1'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        cmd_ready;
	logic [7:0]  rsp_char;
	logic        rsp_valid;
	bus_out_t    gp_tx;
	logic        gp_tx_ack;
	bus_in_t     gp_rx;
	logic        ifc_out;
	logic        ren_out;
	logic        atn_out;
	logic        own_pp_en;
	logic [7:0]  rq [$];
	logic [31:0] s;
	int          ifc_n       = 0;
	int          miscompares = 0;
	int          n_compared  = 0;
	logic [7:0]  ppu_exp [8] = '{8'h3F, 8'h2E, 8'h70, 8'h3F,
		8'h3F, 8'h25, 8'h70, 8'h3F};
	row_t        rows [4] = '{
		'{"rd #4 3",    4'h0, 8'h06, 1'h0, 1'h0, 4, 4},
		'{"rd #6 35",   4'h3, 8'h03, 1'h1, 1'h0, 6, 3},
		'{"rd #5,67",   4'h0, 8'h08, 1'h0, 1'h1, 5, 3},
		'{"rd #1 99+2", 4'h3, 8'h04, 1'h0, 1'h0, 1, 1}};

	always #50 hclk = ~hclk;

	ppu_rd_core #(.TMO_DEF(200)) i_ppu_rd_core (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .cmd_char(cmd_char), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .rsp_char(rsp_char), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .gp_tx(gp_tx), .gp_tx_ack(gp_tx_ack),
		.gp_rx(gp_rx), .cic_lost(cic_lost), .ifc_out(ifc_out),
		.ren_out(ren_out), .atn_out(atn_out), .own_pp_en(own_pp_en));

	gpib_partner i_gpib_partner (
		.hclk(hclk), .gp_tx(gp_tx), .atn_out(atn_out), .ack_dly(ack_dly),
		.talk_len(talk_len), .eoi_last(eoi_last), .talk_now(talk_now),
		.gp_tx_ack(gp_tx_ack), .gp_rx(gp_rx));

	// slow host: ready every other cycle, collects reply bytes
	always @(posedge hclk) begin
		rsp_ready <= ~rsp_ready;
		ifc_prev  <= ifc_out;
		if (ifc_out === 1'h1 && ifc_prev === 1'h0)
			ifc_n++;
		if (rsp_valid === 1'h1 && rsp_ready === 1'h1)
			rq.push_back(rsp_char);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// single whole-word transfer; waits on hready, no fixed latency
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'h1);
		s = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'h1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'h0, a, 32'h0);
		chk(s, e);
	endtask : rdc

	task automatic cmd(input string c);
		for (int i = 0; i <= c.len(); i++) begin
			cmd_char  <= (i == c.len()) ? CH_CR : c[i];
			cmd_valid <= 1'h1;
			do @(posedge hclk); while (cmd_ready !== 1'h1);
		end
		cmd_valid <= 1'h0;
		@(posedge hclk);
	endtask : cmd

	task automatic wait_idle();
		int k;
		repeat (4) @(posedge hclk);
		k = 0;
		do begin
			ahb(1'h0, STAT_OFS, 32'h0);
			k++;
		end while (s[1] !== 1'h1 && k < 3000);
	endtask : wait_idle

	// error field, then clear it for the next case
	task automatic stat(input logic [1:0] e);
		wait_idle();
		chk({30'h0, s[5:4]}, {30'h0, e});
		wr(CTRL_OFS, 32'h5);
	endtask : stat

	task automatic run_read(input row_t r, input logic kick);
		string t;
		int    k;
		ack_dly  <= r.d;
		talk_len <= r.len;
		eoi_last <= r.eoi;
		wr(CTRL_OFS, {30'h0, r.eos, 1'h1});
		rq.delete();
		i_gpib_partner.log_q.delete();
		cmd(r.c);
		if (kick) begin
			repeat (30) @(posedge hclk);
			talk_now <= 1'h1;
			@(posedge hclk);
			talk_now <= 1'h0;
		end
		t = $sformatf("%0d\r\n", r.n);
		for (k = 0; k < 20000 && rq.size() < r.req + t.len(); k++)
			@(posedge hclk);
		wait_idle();
		chk(rq.size(), r.req + t.len());
		for (k = 0; k < r.req + t.len(); k++)
			chk(rq[k], k >= r.req ? t[k - r.req] :
				k < r.n ? 8'(8'h41 + k) : 8'h00);
		if (!kick) begin
			chk(i_gpib_partner.log_q[1], LISTEN_BASE | 8'h05);
			chk(i_gpib_partner.log_q[2], TALK_BASE | 8'h03);
		end
		chk(atn_out, 1'h0);
		$display("test %s done", r.c);
	endtask : run_read

	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// hang guard, well above the expected run length
	initial begin
		repeat (60000) @(posedge hclk);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rdc(CTRL_OFS, CTRL_RST);
		chk(own_pp_en, 1'h1);
		rdc(8'h40, 32'h0);
		$display("test reset done");
		wr(MYADDR_OFS, 32'h5);
		wr(EOS_OFS, 32'h43);
		wr(PPMASK_OFS, 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++)
			run_read(rows[i], 1'h0);
		chk(ifc_n, 1);
		chk(ren_out, 1'h1);
		i_gpib_partner.log_q.delete();
		cmd("ppu 14 5");
		wait_idle();
		for (int i = 0; i < 8; i++)
			chk(i_gpib_partner.log_q[i], ppu_exp[i]);
		rdc(PPMASK_OFS, 32'h7FFF_BFDF);
		chk(own_pp_en, 1'h0);
		i_gpib_partner.log_q.delete();
		cmd("ppu");
		wait_idle();
		chk(i_gpib_partner.log_q.size(), 1);
		chk(i_gpib_partner.log_q[0], PPU_CMD);
		$display("test ppu done");
		cmd("rd");
		stat(2'h3);
		talk_len <= 8'h02;
		eoi_last <= 1'h0;
		cmd("rd #4 3");
		stat(2'h2);
		// control passed away blocks addressed read
		cic_lost <= 1'h1;
		@(posedge hclk);
		cic_lost <= 1'h0;
		i_gpib_partner.log_q.delete();
		cmd("rd #2 3");
		stat(2'h1);
		chk(i_gpib_partner.log_q.size(), 0);
		$display("test errors done");
		run_read('{"rd #2", 4'h1, 8'h02, 1'h1, 1'h0, 2, 2}, 1'h1);
		end_of_test();
	end
endmodule : test_gpib_poll_unconfig_and_read
